// File: rtl/idcr_pkg.sv
package idcr_pkg;
	// configuration indices of this bank
	localparam logic [7:0] IDX_FDC_PP_IRQ = 8'h27;
	localparam logic [7:0] IDX_SERIAL_IRQ = 8'h28;
	localparam logic [7:0] IDX_IR_EXTERNAL_IRQ_INPUT_CTL = 8'h29;
	localparam logic [7:0] IDX_RESERVED_2A = 8'h2a;
	localparam logic [7:0] IDX_FIR_BASE = 8'h2b;
	localparam logic [7:0] IDX_FIR_DMA = 8'h2c;
	localparam logic [7:0] IDX_TURNAROUND = 8'h2d;
	localparam logic [7:0] IDX_SW_SEL_A = 8'h2e;
	localparam logic [7:0] IDX_SW_SEL_B = 8'h2f;
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_TURNAROUND = 8'h03;
	// field positions of the ir / irq input control register
	localparam int PIN_FUNC_BIT = 4;
	localparam int RSVD_BIT = 5;
	localparam int SIRQ_DIS_BIT = 7;
	// writable mask of the control register and dma register
	localparam logic [7:0] CTL_WMASK = 8'hdf;
	localparam logic [7:0] DMA_WMASK = 8'h0f;
	// irq and dma widths
	localparam int IRQ_LINES = 15;
	localparam int DMA_CHANS = 4;
	// turnaround timeout step
	localparam int TURN_STEP_US = 100;
	localparam int CLK_MHZ = 25;
	localparam int TURN_STEP_CYC = TURN_STEP_US * CLK_MHZ;
endpackage

// File: rtl/idcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module idcr_regs (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// configuration port
	input wire logic config_state,
	input wire logic [7:0] config_index_reg,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	// host address decode for the engine window
	input wire logic chip_select_n,
	input wire logic [10:0] host_addr,
	output logic fast_ir_engine_hit,
	output logic [2:0] fast_ir_engine_reg,
	// engine side of the shared registers
	input wire logic eng_timeout_wr,
	input wire logic eng_sw_a_wr,
	input wire logic eng_sw_b_wr,
	input wire logic [7:0] eng_wdata,
	input wire logic eng_soft_reset,
	output logic [7:0] eng_timeout,
	output logic [7:0] eng_sw_a,
	output logic [7:0] eng_sw_b,
	output logic [31:0] turnaround_cycles,
	// interrupt sources
	input wire logic fdc_irq,
	input wire logic pp_irq,
	input wire logic uart1_irq,
	input wire logic uart2_irq,
	input wire logic uart_irq_output_gate1,
	input wire logic uart_irq_output_gate2,
	input wire logic external_irq_input,
	// irq pins, index 0 is line 1
	output logic [14:0] irq_out,
	output logic [14:0] irq_oe,
	// dma
	input wire logic fir_drq,
	output logic [3:0] drq_out,
	output logic [3:0] drq_oe,
	// ir pin function and serial irq
	output logic ir_pin_function_sel,
	output logic serial_irq_disable
);
	logic [7:0] fdc_pp_irq_select;
	logic [7:0] serial_irq_select;
	logic [7:0] ir_and_irq_input_control;
	logic [7:0] fast_ir_base_address;
	logic [7:0] fast_ir_dma_select;
	logic [7:0] ir_turnaround_timeout;
	logic [7:0] sw_select_byte_a;
	logic [7:0] sw_select_byte_b;
	logic ext_irq_s1;
	logic ext_irq_s2;
	logic wr_ok;
	logic [4:0][3:0] sel_code;
	logic [4:0] src_lvl;
	logic [4:0] src_en;

	// writes only land in config state at the addressed index
	assign wr_ok = cfg_wr && config_state;

	// external pin is asynchronous, two flops before use
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ext_irq_s1 <= 1'b0;
			ext_irq_s2 <= 1'b0;
		end
		else
		begin
			ext_irq_s1 <= external_irq_input;
			ext_irq_s2 <= ext_irq_s1;
		end
	end

	// irq routing registers
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			fdc_pp_irq_select <= idcr_pkg::RST_ZERO;
			serial_irq_select <= idcr_pkg::RST_ZERO;
			ir_and_irq_input_control <= idcr_pkg::RST_ZERO;
		end
		else if (wr_ok)
		begin
			unique case (config_index_reg)
				idcr_pkg::IDX_FDC_PP_IRQ:
					fdc_pp_irq_select <= cfg_wdata;
				idcr_pkg::IDX_SERIAL_IRQ:
					serial_irq_select <= cfg_wdata;
				idcr_pkg::IDX_IR_EXTERNAL_IRQ_INPUT_CTL:
					ir_and_irq_input_control <=
						cfg_wdata & idcr_pkg::CTL_WMASK;
				default:
				begin
				end
			endcase
		end
	end

	// engine window base and dma select
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			fast_ir_base_address <= idcr_pkg::RST_ZERO;
			fast_ir_dma_select <= idcr_pkg::RST_ZERO;
		end
		else if (wr_ok)
		begin
			if (config_index_reg == idcr_pkg::IDX_FIR_BASE)
				fast_ir_base_address <= cfg_wdata;
			if (config_index_reg == idcr_pkg::IDX_FIR_DMA)
				fast_ir_dma_select <=
					cfg_wdata & idcr_pkg::DMA_WMASK;
		end
	end

	// one store for the timeout, written from either side;
	// the engine soft reset is deliberately not a term here
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			ir_turnaround_timeout <= idcr_pkg::RST_TURNAROUND;
		else if (wr_ok && config_index_reg == idcr_pkg::IDX_TURNAROUND)
			ir_turnaround_timeout <= cfg_wdata;
		else if (eng_timeout_wr)
			ir_turnaround_timeout <= eng_wdata;
	end

	// software select bytes, single storage shared with the engine;
	// host write wins if both sides write in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			sw_select_byte_a <= idcr_pkg::RST_ZERO;
			sw_select_byte_b <= idcr_pkg::RST_ZERO;
		end
		else
		begin
			if (wr_ok && config_index_reg == idcr_pkg::IDX_SW_SEL_A)
				sw_select_byte_a <= cfg_wdata;
			else if (eng_sw_a_wr)
				sw_select_byte_a <= eng_wdata;
			if (wr_ok && config_index_reg == idcr_pkg::IDX_SW_SEL_B)
				sw_select_byte_b <= cfg_wdata;
			else if (eng_sw_b_wr)
				sw_select_byte_b <= eng_wdata;
		end
	end

	// read data registered; other indices read back as zero
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			cfg_rdata <= idcr_pkg::RST_ZERO;
		else if (cfg_rd && config_state)
		begin
			unique case (config_index_reg)
				idcr_pkg::IDX_FDC_PP_IRQ: cfg_rdata <= fdc_pp_irq_select;
				idcr_pkg::IDX_SERIAL_IRQ: cfg_rdata <= serial_irq_select;
				idcr_pkg::IDX_IR_EXTERNAL_IRQ_INPUT_CTL:
					cfg_rdata <= ir_and_irq_input_control;
				idcr_pkg::IDX_RESERVED_2A: cfg_rdata <= idcr_pkg::RST_ZERO;
				idcr_pkg::IDX_FIR_BASE: cfg_rdata <= fast_ir_base_address;
				idcr_pkg::IDX_FIR_DMA: cfg_rdata <= fast_ir_dma_select;
				idcr_pkg::IDX_TURNAROUND: cfg_rdata <= ir_turnaround_timeout;
				idcr_pkg::IDX_SW_SEL_A: cfg_rdata <= sw_select_byte_a;
				idcr_pkg::IDX_SW_SEL_B: cfg_rdata <= sw_select_byte_b;
				default: cfg_rdata <= idcr_pkg::RST_ZERO;
			endcase
		end
	end

	// mirrored copies seen by the engine
	assign eng_timeout = ir_turnaround_timeout;
	assign eng_sw_a = sw_select_byte_a;
	assign eng_sw_b = sw_select_byte_b;
	assign turnaround_cycles = 32'(ir_turnaround_timeout) *
		32'(idcr_pkg::TURN_STEP_CYC);

	// control bits
	assign ir_pin_function_sel =
		ir_and_irq_input_control[idcr_pkg::PIN_FUNC_BIT];
	assign serial_irq_disable =
		ir_and_irq_input_control[idcr_pkg::SIRQ_DIS_BIT];

	// engine window: base bits 10..3, low three bits pick register
	assign fast_ir_engine_hit = !chip_select_n &&
		(fast_ir_base_address[7:5] != 3'h0) &&
		(host_addr[10:3] == fast_ir_base_address);
	assign fast_ir_engine_reg = host_addr[2:0];

	// interrupt sources: floppy, parallel, uart1, uart2, external
	assign sel_code[0] = fdc_pp_irq_select[7:4];
	assign sel_code[1] = fdc_pp_irq_select[3:0];
	assign sel_code[2] = serial_irq_select[7:4];
	assign sel_code[3] = serial_irq_select[3:0];
	assign sel_code[4] = ir_and_irq_input_control[3:0];
	assign src_lvl = {ext_irq_s2, uart2_irq, uart1_irq, pp_irq, fdc_irq};
	// uart pins float while their gate bit is clear
	assign src_en = {1'b1, uart_irq_output_gate2,
		uart_irq_output_gate1, 2'b11};

	// line n is driven by any source whose code equals n; software
	// must never give one line two sources, so an or suffices
	genvar n;
	generate
		for (n = 0; n < idcr_pkg::IRQ_LINES; n++)
		begin : g_irq
			logic [4:0] hit;
			for (genvar s = 0; s < 5; s++)
			begin : g_src
				assign hit[s] = src_en[s] &&
					(sel_code[s] == 4'(n + 1));
			end
			assign irq_oe[n] = |hit;
			assign irq_out[n] = |(hit & src_lvl);
		end
	endgenerate

	// dma channel a..d for codes 0..3, others float
	genvar d;
	generate
		for (d = 0; d < idcr_pkg::DMA_CHANS; d++)
		begin : g_dma
			assign drq_oe[d] = fast_ir_dma_select[3:0] == 4'(d);
			assign drq_out[d] = drq_oe[d] && fir_drq;
		end
	endgenerate

	// floppy routed to line 3 drives the pin high with its request
	fdc_route_a: assert property (@(posedge ref_clk) disable iff (rst)
		(fdc_pp_irq_select[7:4] == 4'h3) |->
		(irq_oe[2] && irq_out[2] == fdc_irq))
		else $error("floppy irq not on line 3");
	none_float_a: assert property (@(posedge ref_clk) disable iff (rst)
		(fdc_pp_irq_select == 8'h00 && serial_irq_select == 8'h00 &&
		ir_and_irq_input_control[3:0] == 4'h0) |-> (irq_oe == 15'h0))
		else $error("irq driven with nothing selected");
	uart_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		(serial_irq_select[7:4] != 4'h0 && !uart_irq_output_gate1 &&
		fdc_pp_irq_select == 8'h00 &&
		serial_irq_select[3:0] != serial_irq_select[7:4] &&
		ir_and_irq_input_control[3:0] == 4'h0) |->
		!irq_oe[serial_irq_select[7:4] - 4'h1])
		else $error("uart pin driven with gate off");
	cfg_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		(cfg_wr && config_state &&
		config_index_reg == idcr_pkg::IDX_FDC_PP_IRQ) |=>
		(fdc_pp_irq_select == $past(cfg_wdata)))
		else $error("routing write lost");
	cfg_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		(!config_state) |=> $stable(fast_ir_base_address))
		else $error("base changed outside config state");
	rsvd_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
		(ir_and_irq_input_control[idcr_pkg::RSVD_BIT] == 1'b0 &&
		fast_ir_dma_select[7:4] == 4'h0))
		else $error("reserved bit set");
	win_off_a: assert property (@(posedge ref_clk) disable iff (rst)
		(fast_ir_base_address[7:5] == 3'h0) |-> !fast_ir_engine_hit)
		else $error("disabled window decoded");
	soft_rst_a: assert property (@(posedge ref_clk) disable iff (rst)
		(eng_soft_reset && !eng_timeout_wr && !cfg_wr) |=>
		$stable(ir_turnaround_timeout))
		else $error("soft reset touched timeout");
	mirror_a: assert property (@(posedge ref_clk) disable iff (rst)
		(eng_timeout_wr && !(cfg_wr && config_state &&
		config_index_reg == idcr_pkg::IDX_TURNAROUND)) |=>
		(eng_timeout == $past(eng_wdata)))
		else $error("engine timeout write lost");
	dma_none_a: assert property (@(posedge ref_clk) disable iff (rst)
		(fast_ir_dma_select[3:0] == 4'hf) |-> (drq_oe == 4'h0))
		else $error("dma driven with none selected");

	// a source alone in the routing drives exactly its own line
	fdc_any_a: assert property (@(posedge ref_clk) disable iff (rst)
		(fdc_pp_irq_select[7:4] != 4'h0 &&
		fdc_pp_irq_select[3:0] == 4'h0 &&
		serial_irq_select == 8'h00 &&
		ir_and_irq_input_control[3:0] == 4'h0) |->
		(irq_oe == (15'h0001 << (fdc_pp_irq_select[7:4] - 4'h1)) &&
		irq_out[fdc_pp_irq_select[7:4] - 4'h1] == fdc_irq))
		else $error("floppy irq misrouted");
	pp_any_a: assert property (@(posedge ref_clk) disable iff (rst)
		(fdc_pp_irq_select[3:0] != 4'h0 &&
		fdc_pp_irq_select[7:4] == 4'h0 &&
		serial_irq_select == 8'h00 &&
		ir_and_irq_input_control[3:0] == 4'h0) |->
		(irq_oe == (15'h0001 << (fdc_pp_irq_select[3:0] - 4'h1)) &&
		irq_out[fdc_pp_irq_select[3:0] - 4'h1] == pp_irq))
		else $error("parallel irq misrouted");
	uart2_any_a: assert property (@(posedge ref_clk) disable iff (rst)
		(serial_irq_select[3:0] != 4'h0 && uart_irq_output_gate2 &&
		serial_irq_select[7:4] == 4'h0 &&
		fdc_pp_irq_select == 8'h00 &&
		ir_and_irq_input_control[3:0] == 4'h0) |->
		(irq_oe == (15'h0001 << (serial_irq_select[3:0] - 4'h1)) &&
		irq_out[serial_irq_select[3:0] - 4'h1] == uart2_irq))
		else $error("second uart irq misrouted");
	// the external pin reaches its line two clocks late
	ext_any_a: assert property (@(posedge ref_clk) disable iff (rst)
		(ir_and_irq_input_control[3:0] != 4'h0 &&
		fdc_pp_irq_select == 8'h00 && serial_irq_select == 8'h00) |->
		(irq_oe == (15'h0001 << (ir_and_irq_input_control[3:0] -
		4'h1)) && irq_out[ir_and_irq_input_control[3:0] - 4'h1] ==
		$past(external_irq_input, 2)))
		else $error("external irq misrouted");

	// engine dma request goes only to the chosen channel
	dma_route_a: assert property (@(posedge ref_clk) disable iff (rst)
		(fast_ir_dma_select[3:0] < 4'h4) |->
		(drq_oe == (4'h1 << fast_ir_dma_select[1:0]) &&
		drq_out[fast_ir_dma_select[1:0]] == fir_drq))
		else $error("dma request misrouted");
	dma_rsvd_a: assert property (@(posedge ref_clk) disable iff (rst)
		(fast_ir_dma_select[3:0] > 4'h3 &&
		fast_ir_dma_select[3:0] != 4'hf) |-> (drq_oe == 4'h0))
		else $error("reserved dma code drove a channel");

	// register port: masking, refusal, read hold and reset values
	ctl_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		(cfg_wr && config_state &&
		config_index_reg == idcr_pkg::IDX_IR_EXTERNAL_IRQ_INPUT_CTL) |=>
		(ir_and_irq_input_control ==
		($past(cfg_wdata) & idcr_pkg::CTL_WMASK)))
		else $error("control write not masked");
	cfg_off_a: assert property (@(posedge ref_clk) disable iff (rst)
		(cfg_wr && !config_state) |=>
		($stable(fdc_pp_irq_select) && $stable(serial_irq_select) &&
		$stable(ir_and_irq_input_control)))
		else $error("write landed outside config state");
	rd_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!(cfg_rd && config_state) |=> $stable(cfg_rdata))
		else $error("read data changed without a read");
	rd_rsvd_a: assert property (@(posedge ref_clk) disable iff (rst)
		(cfg_rd && config_state &&
		config_index_reg == idcr_pkg::IDX_RESERVED_2A) |=>
		(cfg_rdata == idcr_pkg::RST_ZERO))
		else $error("reserved index read nonzero");
	rst_vals_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(rst) |->
		(ir_turnaround_timeout == idcr_pkg::RST_TURNAROUND &&
		fdc_pp_irq_select == idcr_pkg::RST_ZERO &&
		serial_irq_select == idcr_pkg::RST_ZERO &&
		cfg_rdata == idcr_pkg::RST_ZERO && irq_oe == 15'h0000))
		else $error("reset values wrong");

	// host and engine see one store for the shared bytes
	host_mirror_a: assert property (@(posedge ref_clk) disable iff (rst)
		(cfg_wr && config_state &&
		config_index_reg == idcr_pkg::IDX_TURNAROUND) |=>
		(eng_timeout == $past(cfg_wdata)))
		else $error("host timeout write not mirrored");
	sw_eng_a: assert property (@(posedge ref_clk) disable iff (rst)
		(eng_sw_a_wr && !(wr_ok &&
		config_index_reg == idcr_pkg::IDX_SW_SEL_A)) |=>
		(eng_sw_a == $past(eng_wdata)))
		else $error("engine byte a write lost");
	sw_host_a: assert property (@(posedge ref_clk) disable iff (rst)
		(wr_ok && config_index_reg == idcr_pkg::IDX_SW_SEL_B) |=>
		(eng_sw_b == $past(cfg_wdata)))
		else $error("host byte b not shared");
	cs_high_a: assert property (@(posedge ref_clk) disable iff (rst)
		chip_select_n |-> !fast_ir_engine_hit)
		else $error("window hit without chip select");
endmodule
`default_nettype wire

// File: dv/idcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the configuration port; one-cycle strobes
module idcr_host_model (
	// clock
	input wire logic ref_clk,
	// configuration port
	output var logic config_state,
	output var logic [7:0] config_index_reg,
	output var logic cfg_wr,
	output var logic cfg_rd,
	output var logic [7:0] cfg_wdata
);
	// idle at time zero, outside configuration state
	initial
	begin
		config_state = 1'b0;
		config_index_reg = 8'h00;
		{cfg_wr, cfg_rd} = 2'b00;
		cfg_wdata = 8'h00;
	end
	// enter or leave configuration state between accesses
	task mode(input logic s);
		@(posedge ref_clk);
		config_state <= s;
	endtask
	// data goes inverse once released so a stale sample shows up
	task acc(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge ref_clk);
		config_index_reg <= i;
		cfg_wdata <= d;
		{cfg_wr, cfg_rd} <= {w, !w};
		@(posedge ref_clk);
		{cfg_wr, cfg_rd} <= 2'b00;
		cfg_wdata <= ~d;
	endtask
endmodule
`default_nettype wire

// File: dv/idcr_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
module idcr_regs_tb_top;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic chip_select_n, eng_timeout_wr, eng_sw_a_wr, eng_sw_b_wr;
	logic eng_soft_reset, fdc_irq, pp_irq, uart1_irq, uart2_irq, fir_drq;
	logic uart_irq_output_gate1, uart_irq_output_gate2, external_irq_input;
	logic config_state, cfg_wr, cfg_rd, fast_ir_engine_hit, rd_seen = 1'b0;
	logic ir_pin_function_sel, serial_irq_disable;
	logic [10:0] host_addr;
	logic [7:0] eng_wdata, cfg_rdata, eng_timeout, eng_sw_a, eng_sw_b, lf;
	logic [7:0] config_index_reg, cfg_wdata, exp_rd;
	logic [3:0] c, drq_out, drq_oe;
	logic [2:0] fast_ir_engine_reg;
	logic [31:0] turnaround_cycles;
	logic [14:0] irq_out, irq_oe;
	logic [7:0] expq[$];
	int errors = 0;
	int num_checks = 0;

	always #20 ref_clk = ~ref_clk;

	idcr_host_model host (.*);
	idcr_regs DUT (.*);

	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic logic [14:0] oh(input logic [3:0] k);
		return (k == 4'h0) ? 15'h0000 : 15'h0001 << (k - 4'h1);
	endfunction
	task wr(input logic [7:0] i, input logic [7:0] d);
		host.acc(1'b1, i, d);
	endtask
	// expectation is queued before the strobe so the watcher finds it
	task rd(input logic [7:0] i, input logic [7:0] e);
		expq.push_back(e);
		host.acc(1'b0, i, 8'h00);
	endtask
	// engine pulse: 0 soft reset, 1 timeout, 2 byte a, 3 byte b
	task eng(input int w, input logic [7:0] d);
		@(posedge ref_clk);
		eng_wdata <= d;
		{eng_sw_b_wr, eng_sw_a_wr, eng_timeout_wr, eng_soft_reset} <= 4'(1 << w);
		@(posedge ref_clk);
		{eng_sw_b_wr, eng_sw_a_wr, eng_timeout_wr, eng_soft_reset} <= 4'h0;
	endtask
	task win(input logic [7:0] b, input logic [10:0] a, input logic e);
		wr(8'h2b, b);
		host_addr <= a;
		chip_select_n <= 1'b0;
		#1;
		`CHK(fast_ir_engine_hit, e)
		`CHK(fast_ir_engine_reg, a[2:0])
	endtask
	task results;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// read data lands one cycle after the accepted read strobe
	always @(posedge ref_clk)
	begin
		if (rd_seen)
		begin
			// pop once, the compare macro reads its arguments twice
			exp_rd = expq.pop_front();
			`CHK(cfg_rdata, exp_rd)
		end
		rd_seen <= cfg_rd & config_state;
	end

	// hang guard, well past the roughly five hundred cycles the run needs
	initial
	begin
		#400000;
		errors++;
		results();
	end

	// main sequence
	initial
	begin
		{eng_timeout_wr, eng_sw_a_wr, eng_sw_b_wr, eng_soft_reset} = 4'h0;
		{fdc_irq, pp_irq, uart1_irq, uart2_irq, external_irq_input} = 5'h00;
		{uart_irq_output_gate1, uart_irq_output_gate2, fir_drq} = 3'b110;
		{chip_select_n, host_addr, eng_wdata} = {1'b1, 11'h000, 8'h00};
		lf = 8'h4e;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		host.mode(1'b1);
		for (int i = 8'h27; i <= 8'h2f; i++)
			rd(8'(i), (i == 8'h2d) ? 8'h03 : 8'h00);
		// random bytes where no irq routing lives, so no line is shared
		for (int i = 8'h2a; i <= 8'h2f; i++)
		begin
			lf = lfsr(lf);
			wr(8'(i), lf);
			rd(8'(i), lf & ((i == 8'h2a) ? 8'h00 : (i == 8'h2c) ? 8'h0f : 8'hff));
		end
		wr(8'h29, 8'hf0);
		rd(8'h29, 8'hf0 & idcr_pkg::CTL_WMASK);
		`CHK({ir_pin_function_sel, serial_irq_disable}, 2'b11)
		wr(8'h29, 8'h00);
		#1;
		`CHK({ir_pin_function_sel, serial_irq_disable}, 2'b00)
		host.mode(1'b0);
		wr(8'h27, 8'h55);
		host.mode(1'b1);
		rd(8'h27, 8'h00);
		// every code on every source, one source routed at a time
		for (int s = 0; s < 5; s++)
			for (int k = 1; k <= 16; k++)
			begin
				c = k[3:0];
				wr(8'(8'h27 + s / 2), (s[0] || s == 4) ? {4'h0, c} : {c, 4'h0});
				{fdc_irq, pp_irq, uart1_irq, uart2_irq, external_irq_input} <= {5{c[0]}};
				repeat (3) @(posedge ref_clk);
				#1;
				`CHK(irq_oe, oh(c))
				`CHK(irq_out & oh(c), c[0] ? oh(c) : 15'h0)
			end
		uart_irq_output_gate1 <= 1'b0;
		{uart1_irq, uart2_irq} <= 2'b11;
		wr(8'h28, 8'h12);
		#1;
		`CHK(irq_oe[1:0], 2'b10)
		`CHK(irq_out[1], 1'b1)
		for (int k = 0; k < 5; k++)
		begin
			c = (k < 4) ? 4'(k) : 4'hf;
			wr(8'h2c, {4'h0, c});
			fir_drq <= k[0];
			#1;
			`CHK(drq_oe, (k < 4) ? 4'(1 << k) : 4'h0)
			`CHK(drq_out, (k == 1 || k == 3) ? 4'(1 << k) : 4'h0)
		end
		win(8'h21, 11'h10d, 1'b1);
		win(8'h21, 11'h115, 1'b0);
		win(8'hff, 11'h7fa, 1'b1);
		win(8'h1f, 11'h0fb, 1'b0);
		chip_select_n <= 1'b1;
		#1;
		`CHK(fast_ir_engine_hit, 1'b0)
		wr(8'h2d, 8'h0a);
		#1;
		`CHK(turnaround_cycles, 32'd25000)
		`CHK(eng_timeout, 8'h0a)
		eng(1, 8'h33);
		eng(0, 8'h00);
		rd(8'h2d, 8'h33);
		eng(2, 8'h5a);
		rd(8'h2e, 8'h5a);
		wr(8'h2f, 8'hc3);
		#1;
		`CHK(eng_sw_b, 8'hc3)
		repeat (3) @(posedge ref_clk);
		results();
	end
endmodule
`default_nettype wire
